// ==== common/ecs_regs.vh ====
`ifndef ECS_REGS_VH
`define ECS_REGS_VH

// Status codes reported to the controller
`define ECS_ST_OK        8'h00
`define ECS_ST_OFFSET    8'h02
`define ECS_ST_TABLE     8'h03
`define ECS_ST_LIMITS    8'h04
`define ECS_ST_TWI       8'h05
`define ECS_ST_WDOG      8'h07
`define ECS_ST_CNT_OVF   8'h08
`define ECS_ST_CHKSUM    8'h0a
`define ECS_ST_UNKNOWN   8'h0b
`define ECS_ST_LENGTH    8'h0c
`define ECS_ST_ARG       8'h0d
`define ECS_ST_WPROT     8'h0e
`define ECS_ST_KEY       8'h0f
`define ECS_ST_FIXED     8'h10
`define ECS_ST_ADDR      8'h11
`define ECS_ST_NOFIELD   8'h12
`define ECS_ST_ANALOG    8'h1c
`define ECS_ST_TXCUR     8'h1d
`define ECS_ST_SPEED     8'h1f

// Command bytes
`define ECS_CMD_RD_CNT   8'h46
`define ECS_CMD_INC_CNT  8'h47
`define ECS_CMD_CLR_CNT  8'h49
`define ECS_CMD_RD_DATA  8'h4a
`define ECS_CMD_WR_DATA  8'h4b
`define ECS_CMD_FLD_STAT 8'h4c
`define ECS_CMD_CREATE   8'h4d
`define ECS_CMD_FREE     8'h4e
`define ECS_CMD_RD_STAT  8'h50

// Reset values and reply layout
`define ECS_KEY_RST      8'h55
`define ECS_F0_SIZE      6'd16
`define ECS_ERR_FLAG     8'h80
`define ECS_PROT_BIT     7
`define ECS_REPLY_LAST   2'd2

`endif

// ==== src/ecs_rx_collect.v ====
`timescale 1ns/1ps

// Gathers the bytes of one message, their count and running XOR
module ecs_rx_collect #(
   parameter MAXB = 5
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              byte_vld,
   input  wire [7:0]        byte_dat,
   input  wire              hold,
   input  wire              clr,
   output reg  [2:0]        cnt_r,
   output reg               ovf_r,
   output reg  [7:0]        xsum_r,
   output reg  [MAXB*8-1:0] buf_r
);

   // Bytes beyond MAXB are not stored but still enter the XOR and flag overflow; the length check rejects them
   always @(posedge clk)
   begin
      if (rst || clr)
      begin
         cnt_r  <= 3'd0;
         ovf_r  <= 1'b0;
         xsum_r <= 8'h00;
         buf_r  <= {MAXB*8{1'b0}};
      end
      else if (byte_vld && !hold)
      begin
         xsum_r <= xsum_r ^ byte_dat;
         if (cnt_r < MAXB)
         begin
            buf_r[cnt_r*8 +: 8] <= byte_dat;
            cnt_r               <= cnt_r + 3'd1;
         end
         else
            ovf_r <= 1'b1;
      end
   end

endmodule // ecs_rx_collect

// ==== src/ecs_handler.v ====
`timescale 1ns/1ps
`include "ecs_regs.vh"

// Function
// - With no fault pending the status reads 00h.
// - Init finding a bad angular offset reports 02h.
// - Init finding a corrupt field partition table reports 03h.
// - Init missing analog supervision limits reports 04h.
// - Failure of the internal two-wire memory bus reports 05h.
// - Reset by program supervision reports 07h.
// - Bad message checksum rejects the message with 0Ah.
// - Wrong byte count for the command rejects it with 0Ch.
// - Argument outside the permitted set is refused with 0Dh.
// - Write to a write-protected field is refused with 0Eh, field unchanged.
// - Resizing a fixed-size field is refused with 10h.
// - Word address beyond the field extent is refused with 11h.
// - Access to a field never created is refused with 12h.
// - Excess speed withholds position and reports 1Fh.
// - Analog process signal out of range reports 1Ch.
// - Critical transmitter current or work RAM error reports 1Dh.
// - Command 4Ch answers with the state of one data field.
// - Command 4Eh answers with the unallocated user memory.
// - Protected commands carry a key byte matching the stored key, 55h.
module ecs_handler #(
   parameter FW = 2,
   parameter AW = 5
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire        rx_end,
   input  wire        tx_ready,
   input  wire        init_done,
   input  wire        init_offset_bad,
   input  wire        init_table_bad,
   input  wire        init_limits_bad,
   input  wire        twi_fail,
   input  wire        wdog_flag,
   input  wire        speed_high,
   input  wire        analog_oor,
   input  wire        tx_current_crit,
   input  wire        work_ram_err,
   input  wire [14:0] pos_in,
   output reg         tx_valid,
   output reg  [7:0]  tx_data,
   output reg  [7:0]  status_code,
   output reg         pos_valid,
   output reg  [14:0] pos_out,
   output reg         busy
);

   localparam NF   = 1 << FW;
   localparam SLOT = 1 << AW;
   localparam MEM  = NF * SLOT;

   // One-hot states
   localparam S_IDLE = 3'b001;
   localparam S_EXEC = 3'b010;
   localparam S_SEND = 3'b100;

   reg  [2:0]     state_r;
   reg  [7:0]     mem_r [0:MEM-1];
   reg  [NF-1:0]  fld_ex_r;
   reg  [NF-1:0]  fld_prot_r;
   reg  [NF-1:0]  fld_fix_r;
   reg  [AW:0]    fld_size_r [0:NF-1];
   reg  [7:0]     key_r;
   reg  [7:0]     cnt_r;
   reg  [7:0]     err_r;
   reg  [23:0]    rep_r;
   reg  [1:0]     idx_r;
   reg            first_r;
   reg            twi_q_r;
   reg            oor_q_r;
   reg            txc_q_r;
   reg            spd_q_r;

   wire [2:0]     rx_cnt;
   wire           rx_ovf;
   wire [7:0]     rx_xsum;
   wire [39:0]    rx_buf;

   // Byte collection; frozen while a message is being handled
   ecs_rx_collect #(
      .MAXB (5)
   ) u_collect (
      .clk      (clk),
      .rst      (rst),
      .byte_vld (rx_valid),
      .byte_dat (rx_data),
      .hold     (state_r != S_IDLE),
      .clr      (state_r == S_SEND),
      .cnt_r    (rx_cnt),
      .ovf_r    (rx_ovf),
      .xsum_r   (rx_xsum),
      .buf_r    (rx_buf)
   );

   // Expected message length including checksum; zero marks unknown
   function [2:0] ecs_len;
      input [7:0] c;
      begin
         case (c)
            `ECS_CMD_RD_CNT, `ECS_CMD_INC_CNT,
            `ECS_CMD_FREE, `ECS_CMD_RD_STAT:     ecs_len = 3'd2;
            `ECS_CMD_CLR_CNT, `ECS_CMD_FLD_STAT: ecs_len = 3'd3;
            `ECS_CMD_RD_DATA, `ECS_CMD_CREATE:   ecs_len = 3'd4;
            `ECS_CMD_WR_DATA:                    ecs_len = 3'd5;
            default:                             ecs_len = 3'd0;
         endcase
      end
   endfunction

   wire [7:0]     cmd = rx_buf[7:0];
   wire [7:0]     a1  = rx_buf[15:8];
   wire [7:0]     a2  = rx_buf[23:16];
   wire [7:0]     a3  = rx_buf[31:24];
   wire [FW-1:0]  fld = a1[FW-1:0];
   wire [AW:0]    nsz = a2[AW:0];
   wire [FW+AW-1:0] maddr = {fld, a2[AW-1:0]};

   // Unallocated memory is the total less all created field sizes
   reg  [7:0]     used;
   reg  [7:0]     free_b;
   integer        i;
   always @*
   begin
      used = 8'h00;
      for (i = 0; i < NF; i = i + 1)
         if (fld_ex_r[i])
            used = used + {{(7-AW){1'b0}}, fld_size_r[i]};
      free_b = MEM[7:0] - used;
   end

   // Command evaluation; checks run in a fixed order, first failure wins
   reg  [7:0]     ex_code;
   reg  [7:0]     ex_val;
   reg            do_wr;
   reg            do_new;
   reg            do_inc;
   reg            do_clr;
   reg            do_rdst;
   always @*
   begin
      ex_code = `ECS_ST_OK;
      ex_val  = 8'h00;
      do_wr   = 1'b0;
      do_new  = 1'b0;
      do_inc  = 1'b0;
      do_clr  = 1'b0;
      do_rdst = 1'b0;
      if (ecs_len(cmd) == 3'd0)
         ex_code = `ECS_ST_UNKNOWN;
      else if (rx_ovf || rx_cnt != ecs_len(cmd))
         ex_code = `ECS_ST_LENGTH;
      else if (rx_xsum != 8'h00)
         ex_code = `ECS_ST_CHKSUM;
      else
      begin
         case (cmd)
            `ECS_CMD_RD_CNT:
               ex_val = cnt_r;
            `ECS_CMD_INC_CNT:
            begin
               if (cnt_r == 8'hff)
                  ex_code = `ECS_ST_CNT_OVF;
               else
                  do_inc = 1'b1;
               ex_val = cnt_r;
            end
            `ECS_CMD_CLR_CNT:
            begin
               if (a1 != key_r)
                  ex_code = `ECS_ST_KEY;
               else
                  do_clr = 1'b1;
            end
            `ECS_CMD_RD_DATA, `ECS_CMD_WR_DATA:
            begin
               if (a1 >= NF)
                  ex_code = `ECS_ST_ARG;
               else if (!fld_ex_r[fld])
                  ex_code = `ECS_ST_NOFIELD;
               else if ({1'b0, a2} >= {{(8-AW){1'b0}}, fld_size_r[fld]})
                  ex_code = `ECS_ST_ADDR;
               else if (cmd == `ECS_CMD_WR_DATA && fld_prot_r[fld])
                  ex_code = `ECS_ST_WPROT;
               else
               begin
                  do_wr  = (cmd == `ECS_CMD_WR_DATA);
                  ex_val = mem_r[maddr];
               end
            end
            `ECS_CMD_FLD_STAT:
            begin
               if (a1 >= NF)
                  ex_code = `ECS_ST_ARG;
               else
                  ex_val = {fld_ex_r[fld], fld_prot_r[fld],
                            fld_size_r[fld][5:0]};
            end
            `ECS_CMD_CREATE:
            begin
               if (a1 >= NF || nsz == 0 || nsz > SLOT
                   || a2[6:AW+1] != 0)
                  ex_code = `ECS_ST_ARG;
               else if (fld_ex_r[fld] && fld_fix_r[fld])
                  ex_code = `ECS_ST_FIXED;
               else
                  do_new = 1'b1;
            end
            `ECS_CMD_FREE:
               ex_val = free_b;
            `ECS_CMD_RD_STAT:
            begin
               ex_val  = err_r;
               do_rdst = 1'b1;
            end
            default:
               ex_code = `ECS_ST_UNKNOWN;
         endcase
      end
   end

   // Background fault events; run-time faults on rising edges only, so a standing fault
   // does not keep overwriting a protocol error software has not seen
   reg  [7:0]     bg_code;
   always @*
   begin
      bg_code = `ECS_ST_OK;
      if (first_r && wdog_flag)
         bg_code = `ECS_ST_WDOG;
      else if (init_done && init_offset_bad)
         bg_code = `ECS_ST_OFFSET;
      else if (init_done && init_table_bad)
         bg_code = `ECS_ST_TABLE;
      else if (init_done && init_limits_bad)
         bg_code = `ECS_ST_LIMITS;
      else if (twi_fail && !twi_q_r)
         bg_code = `ECS_ST_TWI;
      else if ((tx_current_crit || work_ram_err) && !txc_q_r)
         bg_code = `ECS_ST_TXCUR;
      else if (analog_oor && !oor_q_r)
         bg_code = `ECS_ST_ANALOG;
      else if (speed_high && !spd_q_r)
         bg_code = `ECS_ST_SPEED;
   end

   wire           exec   = (state_r == S_EXEC);
   wire           ex_err = exec && (ex_code != `ECS_ST_OK);

   // Held error code: a new error wins over the read that clears it
   always @(posedge clk)
   begin
      if (rst)
         err_r <= `ECS_ST_OK;
      else if (ex_err)
         err_r <= ex_code;
      else if (bg_code != `ECS_ST_OK)
         err_r <= bg_code;
      else if (exec && do_rdst)
         err_r <= `ECS_ST_OK;
   end

   // Edge history of fault levels and the post-reset strap capture
   always @(posedge clk)
   begin
      if (rst)
      begin
         first_r <= 1'b1;
         twi_q_r <= 1'b0;
         oor_q_r <= 1'b0;
         txc_q_r <= 1'b0;
         spd_q_r <= 1'b0;
      end
      else
      begin
         first_r <= 1'b0;
         twi_q_r <= twi_fail;
         oor_q_r <= analog_oor;
         txc_q_r <= tx_current_crit || work_ram_err;
         spd_q_r <= speed_high;
      end
   end

   // Field table and key; field 0 is a fixed, protected factory field
   integer        k;
   always @(posedge clk)
   begin
      if (rst)
      begin
         fld_ex_r   <= {{(NF-1){1'b0}}, 1'b1};
         fld_prot_r <= {{(NF-1){1'b0}}, 1'b1};
         fld_fix_r  <= {{(NF-1){1'b0}}, 1'b1};
         key_r      <= `ECS_KEY_RST;
         for (k = 0; k < NF; k = k + 1)
            fld_size_r[k] <= (k == 0) ? `ECS_F0_SIZE : {(AW+1){1'b0}};
      end
      else if (exec && do_new)
      begin
         fld_ex_r[fld]   <= 1'b1;
         fld_prot_r[fld] <= a2[`ECS_PROT_BIT];
         fld_size_r[fld] <= nsz;
      end
   end

   // Data storage; only an accepted write reaches it
   integer        m;
   always @(posedge clk)
   begin
      if (rst)
      begin
         for (m = 0; m < MEM; m = m + 1)
            mem_r[m] <= 8'h00;
      end
      else if (exec && do_wr)
         mem_r[maddr] <= a3;
   end

   // Event counter; saturates rather than wrapping
   always @(posedge clk)
   begin
      if (rst)
         cnt_r <= 8'h00;
      else if (exec && do_clr)
         cnt_r <= 8'h00;
      else if (exec && do_inc)
         cnt_r <= cnt_r + 8'h01;
   end

   // Message sequencer: collect, evaluate one cycle, send 3-byte reply
   wire [7:0]     hdr = ex_err ? (cmd | `ECS_ERR_FLAG) : cmd;
   wire [7:0]     val = ex_err ? ex_code : ex_val;
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_r  <= S_IDLE;
         rep_r    <= 24'h000000;
         idx_r    <= 2'd0;
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         busy     <= 1'b0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               if (rx_end && rx_cnt != 3'd0)
               begin
                  state_r <= S_EXEC;
                  busy    <= 1'b1;
               end
            end
            S_EXEC:
            begin
               rep_r    <= {hdr ^ val, val, hdr};
               tx_data  <= hdr;
               tx_valid <= 1'b1;
               idx_r    <= 2'd0;
               state_r  <= S_SEND;
            end
            S_SEND:
            begin
               if (tx_ready)
               begin
                  if (idx_r == `ECS_REPLY_LAST)
                  begin
                     tx_valid <= 1'b0;
                     busy     <= 1'b0;
                     state_r  <= S_IDLE;
                  end
                  else
                  begin
                     tx_data <= rep_r[(idx_r+2'd1)*8 +: 8];
                     idx_r   <= idx_r + 2'd1;
                  end
               end
            end
            default:
            begin
               state_r  <= S_IDLE;
               tx_valid <= 1'b0;
               busy     <= 1'b0;
            end
         endcase
      end
   end

   // Status mirror and position gate
   always @(posedge clk)
   begin
      if (rst)
      begin
         status_code <= `ECS_ST_OK;
         pos_valid   <= 1'b0;
         pos_out     <= 15'h0000;
      end
      else
      begin
         status_code <= err_r;
         pos_valid   <= !speed_high;
         if (!speed_high)
            pos_out <= pos_in;
      end
   end

endmodule // ecs_handler

// ==== bench/ecs_handler_properties.sv ====
`timescale 1ns/1ps

// Port-level checks of the command handler, all on the one clock
module ecs_handler_checker (
   input wire        clk,
   input wire        rst,
   input wire        rx_valid,
   input wire        rx_end,
   input wire        tx_ready,
   input wire        twi_fail,
   input wire        wdog_flag,
   input wire        speed_high,
   input wire [14:0] pos_in,
   input wire        tx_valid,
   input wire [7:0]  tx_data,
   input wire [7:0]  status_code,
   input wire        pos_valid,
   input wire [14:0] pos_out,
   input wire        busy
);
   reg got_r;

   // Empty end pulses are ignored, so only a message with bytes may start a reply
   always @(posedge clk)
   begin
      if (rst || rx_end)
         got_r <= 1'b0;
      else if (rx_valid && !busy)
         got_r <= 1'b1;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Reset is watched itself, so this one is never disabled
   a_reset_quiet: assert property (disable iff (1'b0) rst |=>
      !tx_valid && !busy && !pos_valid && status_code == 8'h00) else $error("not idle after reset");
   a_answer_time: assert property (rx_end && !busy && got_r |=> busy && !tx_valid ##1 tx_valid)
      else $error("reply not on time");
   a_reply_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped before acceptance");
   a_busy_release: assert property ($fell(busy) |-> $past(tx_valid && tx_ready))
      else $error("busy fell without a reply acceptance");
   a_twi_code: assert property ($rose(twi_fail) && !$past(rst) && !busy |-> ##2 status_code == 8'h05)
      else $error("bus failure code missing");
   a_speed_code: assert property ($rose(speed_high) && !$past(rst) && !busy |-> ##2 status_code == 8'h1f)
      else $error("overspeed code missing");
   a_wdog_code: assert property ($past(rst) && wdog_flag |-> ##2 status_code == 8'h07)
      else $error("supervision reset code missing");
   // Start from a cycle out of reset; the release edge itself still shows reset values
   a_pos_gate: assert property (!rst |=> pos_valid == !$past(speed_high))
      else $error("position valid does not follow speed");
   a_pos_track: assert property (!rst |=>
      pos_out == ($past(speed_high) ? $past(pos_out) : $past(pos_in))) else $error("position not gated");
endmodule // ecs_handler_checker

bind ecs_handler ecs_handler_checker u_chk (
   .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_end(rx_end), .tx_ready(tx_ready),
   .twi_fail(twi_fail), .wdog_flag(wdog_flag), .speed_high(speed_high), .pos_in(pos_in),
   .tx_valid(tx_valid), .tx_data(tx_data), .status_code(status_code), .pos_valid(pos_valid),
   .pos_out(pos_out), .busy(busy));

// ==== bench/ecs_host_model.sv ====
`timescale 1ns/1ps

// Drive controller: sends one message with its checksum, then takes the 3-byte reply
module ecs_host_model (
   input  wire       clk,
   output reg        rx_valid = 1'b0,
   output reg  [7:0] rx_data = 8'h00,
   output reg        rx_end = 1'b0,
   output reg        tx_ready = 1'b0,
   input  wire       tx_valid,
   input  wire [7:0] tx_data
);
   reg     [7:0] rep [0:2];
   integer       slow = 0;
   reg           tmo = 1'b0;

   // Checksum closes the message; bad flips it only where a scenario asks
   task xfer(input integer n, input [39:0] m, input bad);
      integer   k;
      integer   w;
      reg [7:0] x;
   begin
      x = 8'h00;
      for (k = 0; k <= n; k = k + 1)
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data  <= (k == n) ? (x ^ {8{bad}}) : m[39-8*k -: 8];
         x = x ^ m[39-8*k -: 8];
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data; // Released line never shows the last byte
      rx_end   <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
      for (k = 0; k < 3; k = k + 1)
      begin
         repeat (slow) @(posedge clk);
         tx_ready <= 1'b1;
         w = 0;
         @(posedge clk);
         while (!tx_valid && w < 40)
         begin
            @(posedge clk);
            w = w + 1;
         end
         if (w == 40)
            tmo = 1'b1;
         rep[k] = tx_data;
         if (slow > 0 || k == 2)
            tx_ready <= 1'b0;
      end
   end
   endtask
endmodule // ecs_host_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "ecs_regs.vh"

// Drives the handler through the controller model and judges replies and status
module tb_top;
   localparam [63:0] CODES = 64'h1d1d1c1f05040302;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         init_done = 1'b0;
   reg         wdog_flag = 1'b0;
   reg  [7:0]  ev = 8'h00;
   reg  [14:0] pos_in = 15'h0000;
   wire        rx_valid, rx_end, tx_ready, tx_valid, pos_valid, busy;
   wire [7:0]  rx_data, tx_data, status_code;
   wire [14:0] pos_out;
   integer     mismatches = 0;
   integer     tests_run = 0;
   integer     i;

   ecs_handler DUT (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_end(rx_end), .tx_ready(tx_ready), .init_done(init_done), .init_offset_bad(ev[0]),
      .init_table_bad(ev[1]), .init_limits_bad(ev[2]), .twi_fail(ev[3]), .wdog_flag(wdog_flag),
      .speed_high(ev[4]), .analog_oor(ev[5]), .tx_current_crit(ev[6]), .work_ram_err(ev[7]),
      .pos_in(pos_in), .tx_valid(tx_valid), .tx_data(tx_data), .status_code(status_code),
      .pos_valid(pos_valid), .pos_out(pos_out), .busy(busy));
   ecs_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));

   // Clock and a moving position source
   always #4 clk = ~clk;
   always @(posedge clk) pos_in <= pos_in + 15'h0001;

   task give_verdict;
   begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask

   // A reply timeout counts as a mismatch and ends the run
   task check(input [7:0] got, input [7:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp || host.tmo)
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
      if (host.tmo)
         give_verdict;
   end
   endtask

   // Reply is header, value, header xor value
   task msg(input integer n, input [39:0] m, input bad, input [7:0] eh, input [7:0] evl);
   begin
      host.xfer(n, m, bad);
      check(host.rep[0], eh);
      check(host.rep[1], evl);
      check(host.rep[2], eh ^ evl);
   end
   endtask

   // Quiet start: status read of the empty fault store
   task t_idle;
   begin
      check(status_code, `ECS_ST_OK);
      msg(1, 40'h5000000000, 1'b0, 8'h50, `ECS_ST_OK);
   end
   endtask

   // Factory field status, an out-of-range field, free memory against a slow sink
   task t_query;
   begin
      msg(2, 40'h4c00000000, 1'b0, 8'h4c, 8'hd0);
      msg(2, 40'h4c04000000, 1'b0, 8'hcc, `ECS_ST_ARG);
      host.slow = 3;
      msg(1, 40'h4e00000000, 1'b0, 8'h4e, 8'h70);
      host.slow = 0;
   end
   endtask

   // Last word of the protected field survives a refused write of its inverse
   task t_protect;
      reg [7:0] v;
   begin
      host.xfer(3, 40'h4a000f0000, 1'b0);
      check(host.rep[0], 8'h4a);
      v = host.rep[1];
      msg(4, {24'h4b000f, ~v, 8'h00}, 1'b0, 8'hcb, `ECS_ST_WPROT);
      host.xfer(3, 40'h4a000f0000, 1'b0);
      check(host.rep[1], v);
   end
   endtask

   // Counter steps, keyed clear, unknown code, then a new open field written and read back
   task t_count;
   begin
      msg(1, 40'h4700000000, 1'b0, 8'h47, 8'h00);
      msg(1, 40'h4600000000, 1'b0, 8'h46, 8'h01);
      msg(2, 40'h4955000000, 1'b0, 8'h49, 8'h00);
      msg(1, 40'h4600000000, 1'b0, 8'h46, 8'h00);
      msg(1, 40'h4100000000, 1'b0, 8'hc1, `ECS_ST_UNKNOWN);
      msg(3, 40'h4d02080000, 1'b0, 8'h4d, 8'h00);
      msg(2, 40'h4c02000000, 1'b0, 8'h4c, 8'h88);
      msg(4, 40'h4b0203a500, 1'b0, 8'h4b, 8'h00);
      msg(3, 40'h4a02030000, 1'b0, 8'h4a, 8'ha5);
      msg(1, 40'h4e00000000, 1'b0, 8'h4e, 8'h68);
   end
   endtask

   // Refusals, then the held code is read once and cleared by that read
   task t_refuse;
   begin
      msg(3, 40'h4d00100000, 1'b0, 8'hcd, `ECS_ST_FIXED);
      msg(3, 40'h4a00100000, 1'b0, 8'hca, `ECS_ST_ADDR);
      msg(3, 40'h4a01000000, 1'b0, 8'hca, `ECS_ST_NOFIELD);
      msg(1, 40'h4e00000000, 1'b1, 8'hce, `ECS_ST_CHKSUM);
      msg(2, 40'h4e00000000, 1'b1, 8'hce, `ECS_ST_LENGTH);
      msg(3, 40'h4d04040000, 1'b0, 8'hcd, `ECS_ST_ARG);
      msg(2, 40'h4954000000, 1'b0, 8'hc9, `ECS_ST_KEY);
      msg(1, 40'h5000000000, 1'b0, 8'h50, `ECS_ST_KEY);
      msg(1, 40'h5000000000, 1'b0, 8'h50, `ECS_ST_OK);
   end
   endtask

   // One background fault at a time, each with a quiet cycle before the next
   task t_events;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         @(posedge clk);
         ev        <= 8'h01 << i;
         init_done <= (i < 3);
         @(posedge clk);
         init_done <= 1'b0;
         repeat (3) @(posedge clk);
         check(status_code, CODES[8*i +: 8]);
         if (i == 4)
            check({7'h00, pos_valid}, 8'h00);
         ev <= 8'h00;
         // Read and clear, so two faults sharing one code are told apart
         msg(1, 40'h5000000000, 1'b0, 8'h50, CODES[8*i +: 8]);
      end
   end
   endtask

   // Mid-run reset with the supervision cause standing
   task t_wdog;
   begin
      @(posedge clk);
      rst       <= 1'b1;
      wdog_flag <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      wdog_flag <= 1'b0;
      check(status_code, `ECS_ST_WDOG);
   end
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_idle;
      t_query;
      t_protect;
      t_count;
      t_refuse;
      t_events;
      t_wdog;
      give_verdict;
   end
endmodule // tb_top
